// File: inc/vic_consts.vh
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
// Register offsets (word index on the plain register port)
`define VIC_ADDR_W 6
`define VIC_REG_FASTSEL 6'h00
`define VIC_REG_ENABLE 6'h01
`define VIC_REG_RAWSTAT 6'h02
`define VIC_REG_FASTSTAT 6'h03
`define VIC_REG_NORMSTAT 6'h04
`define VIC_REG_VECTADDR 6'h05
`define VIC_REG_PINSTAT 6'h06
`define VIC_REG_PINMASK 6'h07
`define VIC_REG_RISE_LO 6'h08
`define VIC_REG_RISE_HI 6'h09
`define VIC_REG_FALL_LO 6'h0A
`define VIC_REG_FALL_HI 6'h0B
`define VIC_REG_PRIO_BASE 6'h20
`define VIC_REG_ADDR_BASE 6'h10
// Reset values
`define VIC_ZERO32 32'h00000000
`define VIC_PRIO_RST 4'hF
// Line that carries the merged pin edge requests
`define VIC_EXT3_LINE 5'h11
// Map decode fields
`define VIC_PRIO_SEL_BIT 5
`define VIC_ADDR_SLOT_TAG 2'h1
`define VIC_ADDR_IDX_W 4
// Pins reachable through the low register of each pair
`define VIC_PIN_LO_W 32
`endif

// File: hdl/vic_pin_edge.v
`timescale 1ns/1ps
// Edge detector for the port pins; pins are synchronous to core_clk
module vic_pin_edge #(
  parameter NPIN = 46
) (
  input wire core_clk,
  input wire rst,
  input wire [NPIN-1:0] pinIn,
  input wire [NPIN-1:0] riseEn,
  input wire [NPIN-1:0] fallEn,
  input wire [NPIN-1:0] clrMask,
  output reg [NPIN-1:0] pinStat_q
);
  // Previous pin levels
  reg [NPIN-1:0] pinPrev_q;
  // Edges seen this cycle
  wire [NPIN-1:0] edgeHit;

  assign edgeHit = (riseEn & pinIn & ~pinPrev_q) |
                   (fallEn & ~pinIn & pinPrev_q);

  // Sticky flags; a new edge wins over a clear
  always @(posedge core_clk) begin
    if (rst) begin
      pinPrev_q <= {NPIN{1'b0}};
      pinStat_q <= {NPIN{1'b0}};
    end else begin
      pinPrev_q <= pinIn;
      pinStat_q <= (pinStat_q & ~clrMask) | edgeHit;
    end
  end
endmodule // vic_pin_edge

// File: hdl/vic_top.v
`timescale 1ns/1ps
`include "vic_consts.vh"
// Contract
// - 32 inputs, each fast or vectored
// - Fast class beats vectored class
// - Fast output ORs active fast requests
// - Readable word of requesting fast sources
// - Non-fast inputs vectored, programmable priority
// - Equal priority: lowest channel wins
// - Normal output ORs active vectored requests
// - Readable handler address of winner (zero for a winner on 16..31)
// - One line per peripheral, pre-combined
// - Port pins interrupt on chosen edges (pins 0..31 only; 32..45 never reach it)
// - Pin edges merged onto line 17
module vic_top #(
  parameter NIN = 32,
  parameter NPIN = 46,
  parameter PRIO_W = 4
) (
  input wire core_clk,
  input wire rst,
  input wire [NIN-1:0] irqIn,
  input wire [NPIN-1:0] pinIn,
  input wire [`VIC_ADDR_W-1:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  output wire fastIrq,
  output wire normIrq,
  output wire pinIrq
);
  // Class select: 1 = fast
  reg [NIN-1:0] fastSel_q;
  // Per-input enable
  reg [NIN-1:0] enable_q;
  // Priority levels, 0 is most urgent
  reg [PRIO_W-1:0] prio_q [0:NIN-1];
  // Handler addresses
  reg [31:0] vecAddr_q [0:NIN-1];
  // Pin edge selects and mask
  reg [NPIN-1:0] riseEn_q;
  reg [NPIN-1:0] fallEn_q;
  reg [NPIN-1:0] pinMask_q;
  // Pin status from the edge detector
  wire [NPIN-1:0] pinStat;
  // Clear strobe to pin status
  reg [NPIN-1:0] pinClr;
  // Effective request lines
  wire [NIN-1:0] rawReq;
  wire [NIN-1:0] fastReq;
  wire [NIN-1:0] normReq;
  // Winner search results
  reg [31:0] winAddr;
  reg winFound;
  reg [PRIO_W-1:0] winPrio;
  integer i;

  // Limitations worth knowing before use:
  // only channels 0..15 own a handler slot, so a
  // winner on 16..31 reads back a zero address;
  // pins 32..45 latch edges but cannot be cleared
  // and never reach the pin interrupt, since the
  // status and mask words only carry the low pins.

  // Slot decode shared by the write and read paths
  // Upper half of the map holds priority slots
  function isPrioSlot(input [`VIC_ADDR_W-1:0] a);
    begin
      isPrioSlot = a[`VIC_PRIO_SEL_BIT];
    end
  endfunction

  // Handler address slots sit in the second quarter
  function isAddrSlot(input [`VIC_ADDR_W-1:0] a);
    begin
      isAddrSlot = (a[`VIC_ADDR_W-1:`VIC_ADDR_W-2] == `VIC_ADDR_SLOT_TAG);
    end
  endfunction

  // Channel number of a priority slot
  function [4:0] prioIdx(input [`VIC_ADDR_W-1:0] a);
    begin
      prioIdx = a[`VIC_PRIO_SEL_BIT-1:0];
    end
  endfunction

  // Channel number of a handler slot, 0..15 only
  function [4:0] addrIdx(input [`VIC_ADDR_W-1:0] a);
    begin
      addrIdx = {1'h0, a[`VIC_ADDR_IDX_W-1:0]};
    end
  endfunction

  // Priority level widened to a bus word
  function [31:0] prioWord(input [PRIO_W-1:0] p);
    begin
      prioWord = {{(32-PRIO_W){1'h0}}, p};
    end
  endfunction

  // Low pins of a pin field as a bus word
  function [31:0] lowWord(input [NPIN-1:0] v);
    begin
      lowWord = v[`VIC_PIN_LO_W-1:0];
    end
  endfunction

  // High pins of a pin field, zero padded
  function [31:0] hiWord(input [NPIN-1:0] v);
    begin
      hiWord = {{(64-NPIN){1'h0}}, v[NPIN-1:`VIC_PIN_LO_W]};
    end
  endfunction

  // Write data bits that land in the high pins
  function [NPIN-`VIC_PIN_LO_W-1:0] hiField(input [31:0] d);
    begin
      hiField = d[NPIN-`VIC_PIN_LO_W-1:0];
    end
  endfunction

  // Clear mask: low pins only, high pins never clear
  function [NPIN-1:0] w1cMask(input [31:0] d);
    begin
      w1cMask = {{(NPIN-`VIC_PIN_LO_W){1'h0}}, d};
    end
  endfunction

  // Place one request bit on the merge line
  function [NIN-1:0] lineBit(input b);
    begin
      lineBit = {{(NIN-1){1'h0}}, b} << `VIC_EXT3_LINE;
    end
  endfunction

  // Edge detection for the port pins
  vic_pin_edge #(
    .NPIN(NPIN)
  ) uPinEdge (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(pinIn),
    .riseEn(riseEn_q),
    .fallEn(fallEn_q),
    .clrMask(pinClr),
    .pinStat_q(pinStat)
  );

  // Pin interrupt is level while any unmasked flag stands
  assign pinIrq = |(pinStat & pinMask_q);

  // each line may be pre-combined
  // The merged line is still a normal line: class,
  // enable and priority apply to it like any other
  assign rawReq = irqIn | lineBit(pinIrq);

  assign fastReq = rawReq & enable_q & fastSel_q;
  assign normReq = rawReq & enable_q & ~fastSel_q;

  assign fastIrq = |fastReq;
  assign normIrq = |normReq;

  // Winner search over vectored requests
  always @* begin
    winAddr = `VIC_ZERO32;
    winFound = 1'b0;
    winPrio = {PRIO_W{1'b1}};
    for (i = 0; i < NIN; i = i + 1) begin
      if (normReq[i] && (!winFound || prio_q[i] < winPrio)) begin
        winFound = 1'b1;
        winPrio = prio_q[i];
        winAddr = vecAddr_q[i];
      end
    end
  end

  // Write-one-to-clear decode for pin status
  always @* begin
    pinClr = {NPIN{1'b0}};
    if (regWr && regAddr == `VIC_REG_PINSTAT) begin
      // Ones clear low pins; a same-cycle edge still wins
      pinClr = w1cMask(regWdata);
    end
  end

  // Register writes
  always @(posedge core_clk) begin
    if (rst) begin
      fastSel_q <= `VIC_ZERO32;
      enable_q <= `VIC_ZERO32;
      riseEn_q <= {NPIN{1'b0}};
      fallEn_q <= {NPIN{1'b0}};
      pinMask_q <= {NPIN{1'b0}};
      for (i = 0; i < NIN; i = i + 1) begin
        prio_q[i] <= `VIC_PRIO_RST;
        vecAddr_q[i] <= `VIC_ZERO32;
      end
    end else if (regWr) begin
      case (regAddr)
        `VIC_REG_FASTSEL: begin
          fastSel_q <= regWdata;
        end
        `VIC_REG_ENABLE: begin
          enable_q <= regWdata;
        end
        // Mask covers the low pins only
        `VIC_REG_PINMASK: begin
          pinMask_q[`VIC_PIN_LO_W-1:0] <= regWdata;
        end
        `VIC_REG_RISE_LO: begin
          riseEn_q[`VIC_PIN_LO_W-1:0] <= regWdata;
        end
        `VIC_REG_RISE_HI: begin
          riseEn_q[NPIN-1:`VIC_PIN_LO_W] <= hiField(regWdata);
        end
        `VIC_REG_FALL_LO: begin
          fallEn_q[`VIC_PIN_LO_W-1:0] <= regWdata;
        end
        `VIC_REG_FALL_HI: begin
          fallEn_q[NPIN-1:`VIC_PIN_LO_W] <= hiField(regWdata);
        end
        default: begin
          if (isPrioSlot(regAddr)) begin
            prio_q[prioIdx(regAddr)] <= regWdata[PRIO_W-1:0];
          end else if (isAddrSlot(regAddr)) begin
            // Address slots 0x10..0x1F hold channels 0..15 only
            vecAddr_q[addrIdx(regAddr)] <= regWdata;
          end
          // Anything else is ignored on purpose
        end
      endcase
    end
  end

  // Read data, one cycle after the strobe; zero otherwise
  always @(posedge core_clk) begin
    if (rst) begin
      regRdata <= `VIC_ZERO32;
    end else if (regRd) begin
      case (regAddr)
        // Class and enable words read back as written
        `VIC_REG_FASTSEL: regRdata <= fastSel_q;
        `VIC_REG_ENABLE: regRdata <= enable_q;
        // Raw lines before class split and enable
        `VIC_REG_RAWSTAT: regRdata <= rawReq;
        `VIC_REG_FASTSTAT: regRdata <= fastReq;
        // Enabled vectored requests
        `VIC_REG_NORMSTAT: regRdata <= normReq;
        `VIC_REG_VECTADDR: regRdata <= winAddr;
        // Only the low pins are visible in status and mask
        `VIC_REG_PINSTAT: regRdata <= lowWord(pinStat);
        `VIC_REG_PINMASK: regRdata <= lowWord(pinMask_q);
        // Edge selects, low and high halves
        `VIC_REG_RISE_LO: regRdata <= lowWord(riseEn_q);
        `VIC_REG_RISE_HI: regRdata <= hiWord(riseEn_q);
        `VIC_REG_FALL_LO: regRdata <= lowWord(fallEn_q);
        `VIC_REG_FALL_HI: regRdata <= hiWord(fallEn_q);
        default: begin
          // Priority slots
          if (isPrioSlot(regAddr)) begin
            regRdata <= prioWord(prio_q[prioIdx(regAddr)]);
          // Handler address slots
          end else if (isAddrSlot(regAddr)) begin
            regRdata <= vecAddr_q[addrIdx(regAddr)];
          // Unmapped words read as zero
          end else begin
            regRdata <= `VIC_ZERO32;
          end
        end
      endcase
    end else begin
      regRdata <= `VIC_ZERO32;
    end
  end
endmodule // vic_top

// File: tb/vic_core_model.sv
`timescale 1ns/1ps
// Core side: records which handler class it would enter
module vic_core_model (
  input wire core_clk,
  input wire rst,
  input wire fastIrq,
  input wire normIrq,
  output reg [1:0] entry_q
);
  // Fast entry pre-empts normal entry
  always @(posedge core_clk) begin
    if (rst) entry_q <= 2'h0;
    else entry_q <= fastIrq ? 2'h2 : {1'h0, normIrq};
  end
endmodule // vic_core_model

// File: tb/vic_monitor.sv
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_monitor (
  input wire core_clk,
  input wire rst,
  input wire [31:0] irqIn,
  input wire [5:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdata,
  input wire fastIrq,
  input wire normIrq,
  input wire pinIrq
);
  reg [31:0] fs_q; // Shadow class word
  reg [31:0] en_q; // Shadow enable word
  wire [31:0] req = irqIn | ({31'h0, pinIrq} << `VIC_EXT3_LINE);
  wire [31:0] fReq = req & fs_q & en_q;
  wire [31:0] nReq = req & ~fs_q & en_q;
  // Snoop writes, so no peeking inside is needed
  always @(posedge core_clk) begin
    if (rst) fs_q <= 32'h0;
    else if (regWr && regAddr == `VIC_REG_FASTSEL) fs_q <= regWdata;
    if (rst) en_q <= 32'h0;
    else if (regWr && regAddr == `VIC_REG_ENABLE) en_q <= regWdata;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_fast_or: assert property (fastIrq == |fReq)
    else $error("fast output wrong");
  a_norm_or: assert property (normIrq == |nReq)
    else $error("normal output wrong");
  a_fast_word: assert property (regRd && regAddr == 6'h03
    |=> regRdata == $past(fReq)) else $error("fast word wrong");
  a_norm_word: assert property (regRd && regAddr == 6'h04
    |=> regRdata == $past(nReq)) else $error("normal word wrong");
  a_en_word: assert property (regRd && regAddr == 6'h01
    |=> regRdata == $past(en_q)) else $error("enable word wrong");
  a_ext_merge: assert property (pinIrq && en_q[17] && !fs_q[17]
    |-> normIrq) else $error("pin merge lost");
  a_rd_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside slot");
  a_unmapped: assert property (regRd && regAddr == 6'h0C
    |=> regRdata == 32'h0) else $error("unmapped read not zero");
endmodule // vic_monitor
bind vic_top vic_monitor mon (.core_clk(core_clk), .rst(rst), .irqIn(irqIn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .fastIrq(fastIrq), .normIrq(normIrq), .pinIrq(pinIrq));

// File: tb/vectored_interrupt_controller_bench.sv
`timescale 1ns/1ps
module vectored_interrupt_controller_bench;
  reg core_clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0;
  reg [31:0] irqIn = 32'h0, regWdata = 32'h0;
  reg [45:0] pinIn = 46'h0;
  reg [5:0] regAddr = 6'h0;
  wire [31:0] regRdata;
  wire fastIrq, normIrq, pinIrq;
  wire [1:0] entry;
  integer n_errors = 0, n_checks = 0, i;
  vic_top dut (.core_clk(core_clk), .rst(rst), .irqIn(irqIn), .pinIn(pinIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .fastIrq(fastIrq), .normIrq(normIrq),
    .pinIrq(pinIrq));
  vic_core_model core (.core_clk(core_clk), .rst(rst), .fastIrq(fastIrq),
    .normIrq(normIrq), .entry_q(entry));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task chk(input [31:0] got, input [31:0] exp, input string nm);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // Gap cycle first, so strobes never get two values in one step
  task wr(input [5:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      regAddr <= a; regWdata <= d; regWr <= 1'h1;
      @(posedge core_clk);
      regWr <= 1'h0;
    end
  endtask
  task rd(input [5:0] a, input [31:0] exp, input string nm);
    begin
      @(posedge core_clk);
      regAddr <= a; regRd <= 1'h1;
      @(posedge core_clk);
      regRd <= 1'h0;
      #1 chk(regRdata, exp, nm);
    end
  endtask
  task irq(input [2:0] e);
    #1 chk({fastIrq, normIrq, pinIrq}, e, "irq");
  endtask
  task t_reset;
    begin
      irqIn <= 32'hFFFFFFFF;
      irq(3'h0);
      rd(6'h01, 32'h0, "enable");
      rd(6'h20, 32'hF, "prio");
      wr(6'h0C, 32'hFFFFFFFF);
      rd(6'h0C, 32'h0, "unmapped");
    end
  endtask
  task t_fast;
    begin
      wr(6'h00, 32'h208);
      wr(6'h01, 32'hFFFFFFFF);
      irqIn <= 32'h228;
      irq(3'h6);
      rd(6'h03, 32'h208, "faststat");
      rd(6'h04, 32'h20, "normstat");
      #1 chk(entry, 2'h2, "entry");
      irqIn <= 32'h20;
      irq(3'h2);
    end
  endtask
  task t_vect;
    begin
      wr(6'h00, 32'h0);
      for (i = 2; i < 7; i = i + 2) begin
        wr(6'h10 + i, 32'hA0 + i);
        wr(6'h20 + i, 32'h2);
      end
      wr(6'h22, 32'h5);
      irqIn <= 32'h54;
      rd(6'h05, 32'hA4, "vect tie");
      wr(6'h26, 32'h1);
      rd(6'h05, 32'hA6, "vect prio");
      irqIn <= 32'h4;
      rd(6'h05, 32'hA2, "vect one");
      wr(6'h01, 32'hFFFFFFFB);
      irq(3'h0);
    end
  endtask
  task t_pin;
    begin
      irqIn <= 32'h0;
      wr(6'h01, 32'h20000);
      wr(6'h07, 32'h1);
      wr(6'h08, 32'h1);
      pinIn <= 46'h1;
      repeat (3) @(posedge core_clk);
      irq(3'h3);
      rd(6'h02, 32'h20000, "raw");
      rd(6'h06, 32'h1, "pinstat");
      wr(6'h06, 32'h1);
      irq(3'h0);
      pinIn <= 46'h0;
      repeat (3) @(posedge core_clk);
      rd(6'h06, 32'h0, "no fall");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_reset;
    t_fast;
    t_vect;
    t_pin;
    close_out;
  end
endmodule // vectored_interrupt_controller_bench
